// File: design/apc_alert_top.v
/*
  Alert pin conditioning: configuration and force/polarity registers,
  shared comparator enables, glitch filters and fault latches, and the
  two alert pins (A open-drain, B push-pull).
  Assumes comparator inputs are asynchronous and that register accesses
  arrive as decoded command-code strobes from the serial front end.
*/
// Overview of operation
// - 16-bit config word, resets to zero
// - Pin B bits 14..12 choose bypass paths
// - Pin A bits 11..9 choose bypass paths
// - Filters and latches shared by both pins
// - Filter codes give 0, 2, 4, 8 us
// - Events shorter than filter time suppressed
// - Bits 8..7 set overcurrent filter time
// - Bits 6..5 set undervoltage filter time
// - Bits 4..3 set overvoltage filter time
// - Bit 2 enables overcurrent comparator
// - Bit 1 enables overvoltage comparator
// - Bit 0 enables undervoltage comparator
// - 8-bit force/polarity byte, resets to zero
// - Bits 3, 2 set pin active levels
// - Bits 1, 0 force pins active
// - Clear-faults command resets fault status
// - Pin A open-drain, pin B push-pull
// - Over-temperature latches flag until cleared
`timescale 1ns/100ps
`include "apc_defs.vh"

module apc_alert_top (
  input  wire        ref_clk,
  input  wire        rst_n,
  input  wire [7:0]  reg_cmd,
  input  wire        reg_wr,
  input  wire        reg_send,
  input  wire        reg_rd,
  input  wire [15:0] reg_wdata,
  output reg  [15:0] reg_rdata,
  output wire        reg_rvalid,
  input  wire        ov_cmp_in,
  input  wire        ot_cmp_in,
  input  wire        uv_cmp_in,
  input  wire        oc_cmp_in,
  output wire        overcurrent_comp_on,
  output wire        overvoltage_comp_on,
  output wire        undervoltage_comp_on,
  output wire        ov_flag,
  output wire        uv_flag,
  output wire        oc_flag,
  output wire        overtemp_flag,
  output wire        alert_out_a_o,
  output reg         alert_out_a_oe,
  output reg         alert_out_b
);

  // ----------------------------------------------------------------------
  // Register storage
  // ----------------------------------------------------------------------
  reg  [15:0] alert_interrupt_config;
  reg  [7:0]  alert_force_polarity;
  reg         rd_pending;

  wire        hit_config;
  wire        hit_force;
  wire        hit_clear;

  assign hit_config = (reg_cmd == `APC_CMD_INT_CONFIG);
  assign hit_force  = (reg_cmd == `APC_CMD_FORCE_POLARITY);
  assign hit_clear  = (reg_cmd == `APC_CMD_CLEAR_FAULTS);

  always @(posedge ref_clk) begin
    if (!rst_n)
      alert_interrupt_config <= `APC_INT_CONFIG_RST;
    else if (reg_wr && hit_config)
      alert_interrupt_config <= reg_wdata & `APC_INT_CONFIG_MASK;
  end

  always @(posedge ref_clk) begin
    if (!rst_n)
      alert_force_polarity <= `APC_FORCE_POLARITY_RST;
    else if (reg_wr && hit_force)
      alert_force_polarity <= reg_wdata[7:0] & `APC_FORCE_POLARITY_MASK;
  end

  // ----------------------------------------------------------------------
  // Read path
  // ----------------------------------------------------------------------
  // Unmapped codes and the write-only clear command read as zero
  always @(posedge ref_clk) begin
    if (!rst_n) begin
      reg_rdata  <= 16'h0000;
      rd_pending <= 1'b0;
    end else begin
      rd_pending <= reg_rd;
      if (reg_rd) begin
        if (hit_config)
          reg_rdata <= alert_interrupt_config;
        else if (hit_force)
          reg_rdata <= {8'h00, alert_force_polarity};
        else
          reg_rdata <= 16'h0000;
      end
    end
  end

  assign reg_rvalid = rd_pending;

  // ----------------------------------------------------------------------
  // Field decode
  // ----------------------------------------------------------------------
  wire [1:0] overcurrent_glitch_time;
  wire [1:0] undervoltage_glitch_time;
  wire [1:0] overvoltage_glitch_time;
  wire       second_pin_active_level;
  wire       first_pin_active_level;
  wire       second_pin_force;
  wire       first_pin_force;
  wire [2:0] second_pin_bypass_sel;
  wire [2:0] first_pin_bypass_sel;

  assign overcurrent_glitch_time  =
    alert_interrupt_config[`APC_OC_TIME_HI:`APC_OC_TIME_LO];
  assign undervoltage_glitch_time =
    alert_interrupt_config[`APC_UV_TIME_HI:`APC_UV_TIME_LO];
  assign overvoltage_glitch_time  =
    alert_interrupt_config[`APC_OV_TIME_HI:`APC_OV_TIME_LO];

  assign overcurrent_comp_on  = alert_interrupt_config[`APC_OC_ON_BIT];
  assign overvoltage_comp_on  = alert_interrupt_config[`APC_OV_ON_BIT];
  assign undervoltage_comp_on = alert_interrupt_config[`APC_UV_ON_BIT];

  // Pin B path selects, ordered {ov, uv, oc}
  assign second_pin_bypass_sel = {alert_interrupt_config[`APC_B_BYPASS_OV],
                                  alert_interrupt_config[`APC_B_BYPASS_UV],
                                  alert_interrupt_config[`APC_B_BYPASS_OC]};
  // Pin A path selects, ordered {ov, uv, oc}
  assign first_pin_bypass_sel  = {alert_interrupt_config[`APC_A_BYPASS_OV],
                                  alert_interrupt_config[`APC_A_BYPASS_UV],
                                  alert_interrupt_config[`APC_A_BYPASS_OC]};

  assign second_pin_active_level = alert_force_polarity[`APC_B_LEVEL_BIT];
  assign first_pin_active_level  = alert_force_polarity[`APC_A_LEVEL_BIT];
  assign second_pin_force = alert_force_polarity[`APC_B_FORCE_BIT];
  assign first_pin_force  = alert_force_polarity[`APC_A_FORCE_BIT];

  // ----------------------------------------------------------------------
  // Comparator synchronisers
  // ----------------------------------------------------------------------
  // Order {ot, ov, uv, oc}; the first stage feeds only the second
  reg [3:0] cmp_meta;
  reg [3:0] cmp_sync;

  always @(posedge ref_clk) begin
    if (!rst_n) begin
      cmp_meta <= 4'h0;
      cmp_sync <= 4'h0;
    end else begin
      cmp_meta <= {ot_cmp_in, ov_cmp_in, uv_cmp_in, oc_cmp_in};
      cmp_sync <= cmp_meta;
    end
  end

  // ----------------------------------------------------------------------
  // Enabled comparator events
  // ----------------------------------------------------------------------
  // A powered-down comparator can float, so its output is gated here too.
  // Over-temperature has its own comparator input but shares the overvoltage enable.
  wire ot_live;
  wire ov_live;
  wire uv_live;
  wire oc_live;
  wire ovot_live;

  assign ot_live   = cmp_sync[3] & overvoltage_comp_on;
  assign ov_live   = cmp_sync[2] & overvoltage_comp_on;
  assign uv_live   = cmp_sync[1] & undervoltage_comp_on;
  assign oc_live   = cmp_sync[0] & overcurrent_comp_on;
  assign ovot_live = ov_live | ot_live;

  // ----------------------------------------------------------------------
  // Shared glitch filters
  // ----------------------------------------------------------------------
  wire ov_filt;
  wire ot_filt;
  wire uv_filt;
  wire oc_filt;

  // One filter per comparator for both pins
  apc_glitch_filter u_ov_filter (
    .ref_clk   (ref_clk),
    .rst_n     (rst_n),
    .event_in  (ov_live),
    .time_sel  (overvoltage_glitch_time),
    .event_out (ov_filt)
  );

  // Over-temperature rides the overvoltage filter setting
  apc_glitch_filter u_ot_filter (
    .ref_clk   (ref_clk),
    .rst_n     (rst_n),
    .event_in  (ot_live),
    .time_sel  (overvoltage_glitch_time),
    .event_out (ot_filt)
  );

  apc_glitch_filter u_uv_filter (
    .ref_clk   (ref_clk),
    .rst_n     (rst_n),
    .event_in  (uv_live),
    .time_sel  (undervoltage_glitch_time),
    .event_out (uv_filt)
  );

  apc_glitch_filter u_oc_filter (
    .ref_clk   (ref_clk),
    .rst_n     (rst_n),
    .event_in  (oc_live),
    .time_sel  (overcurrent_glitch_time),
    .event_out (oc_filt)
  );

  // ----------------------------------------------------------------------
  // Fault latches
  // ----------------------------------------------------------------------
  // Order {ot, ov, uv, oc}. A filtered event in the same cycle as the
  // clear command keeps its bit set, so no fault is lost.
  reg  [3:0] fault_latch;
  reg  [3:0] next_fault_latch;
  wire [3:0] fault_set;
  wire       fault_clear;

  assign fault_set   = {ot_filt, ov_filt, uv_filt, oc_filt};
  assign fault_clear = reg_send && hit_clear;

  // Sticky fault bits; set wins over a clear in the same cycle
  always @* begin
    next_fault_latch = fault_latch;
    if (fault_clear)
      next_fault_latch = 4'h0;
    next_fault_latch = next_fault_latch | fault_set;
  end

  always @(posedge ref_clk) begin
    if (!rst_n)
      fault_latch <= 4'h0;
    else
      fault_latch <= next_fault_latch;
  end

  assign overtemp_flag = fault_latch[3];
  assign ov_flag       = fault_latch[2];
  assign uv_flag       = fault_latch[1];
  assign oc_flag       = fault_latch[0];

  // ----------------------------------------------------------------------
  // Per-pin path selection
  // ----------------------------------------------------------------------
  wire [2:0] latched_paths;
  wire [2:0] direct_paths;

  // Shared latches, grouped {ov/ot, uv, oc}
  assign latched_paths = {fault_latch[3] | fault_latch[2],
                          fault_latch[1], fault_latch[0]};
  assign direct_paths  = {ovot_live, uv_live, oc_live};

  function route_alert;
    input [2:0] bypass_sel;
    input [2:0] latched;
    input [2:0] direct;
    input       force_on;
    begin
      route_alert = (|(~bypass_sel & latched)) |
                    (|(bypass_sel & direct)) | force_on;
    end
  endfunction

  function pin_level;
    input asserted;
    input active_high;
    begin
      pin_level = asserted ? active_high : ~active_high;
    end
  endfunction

  wire a_asserted;
  wire b_asserted;

  assign a_asserted = route_alert(first_pin_bypass_sel, latched_paths,
                                  direct_paths, first_pin_force);
  assign b_asserted = route_alert(second_pin_bypass_sel, latched_paths,
                                  direct_paths, second_pin_force);

  // ----------------------------------------------------------------------
  // Pin drivers
  // ----------------------------------------------------------------------
  // Registered so the pins never glitch on decode changes; costs one cycle.
  // Open-drain pin A only ever pulls low, so its data is tied low and the
  // enable carries the level.
  assign alert_out_a_o = 1'b0;

  reg        next_alert_out_a_oe;
  reg        next_alert_out_b;

  always @* begin
    next_alert_out_a_oe = ~pin_level(a_asserted, first_pin_active_level);
    next_alert_out_b    = pin_level(b_asserted, second_pin_active_level);
  end

  // Open-drain and push-pull stages
  // Reset leaves both pins deasserted for the default active-low levels
  always @(posedge ref_clk) begin
    if (!rst_n) begin
      alert_out_a_oe <= 1'b0;
      alert_out_b    <= 1'b1;
    end else begin
      alert_out_a_oe <= next_alert_out_a_oe;
      alert_out_b    <= next_alert_out_b;
    end
  end

endmodule // apc_alert_top

// File: design/apc_glitch_filter.v
/*
  One digital glitch filter: passes an event only after it has stood
  continuously for the selected time (0, 2, 4 or 8 us).
  Assumes event_in is already synchronous to ref_clk.
*/
`timescale 1ns/100ps
`include "apc_defs.vh"

module apc_glitch_filter (
  input  wire       ref_clk,
  input  wire       rst_n,
  input  wire       event_in,
  input  wire [1:0] time_sel,
  output reg        event_out
);

  reg [`APC_FILT_CNT_W-1:0] run_cnt;
  wire [`APC_FILT_CNT_W-1:0] limit;

  function [`APC_FILT_CNT_W-1:0] sel_to_cycles;
    input [1:0] sel;
    begin
      case (sel)
        2'h0:    sel_to_cycles = `APC_FILT_T0_CYC;
        2'h1:    sel_to_cycles = `APC_FILT_T1_CYC;
        2'h2:    sel_to_cycles = `APC_FILT_T2_CYC;
        default: sel_to_cycles = `APC_FILT_T3_CYC;
      endcase
    end
  endfunction

  assign limit = sel_to_cycles(time_sel);

  // ----------------------------------------------------------------------
  // Persistence counter
  // ----------------------------------------------------------------------
  // Suppress short events
  always @(posedge ref_clk) begin
    if (!rst_n) begin
      run_cnt   <= {`APC_FILT_CNT_W{1'b0}};
      event_out <= 1'b0;
    end else if (!event_in) begin
      // Any gap restarts the count, so only unbroken events pass
      run_cnt   <= {`APC_FILT_CNT_W{1'b0}};
      event_out <= 1'b0;
    end else begin
      if (run_cnt < limit)
        run_cnt <= run_cnt + 1'b1;
      event_out <= (run_cnt >= limit);
    end
  end

endmodule // apc_glitch_filter

// File: pkg/apc_defs.vh
/*
  Constants for the alert pin conditioning block: command codes, field
  positions, reset values and glitch filter timing.
  Assumes ref_clk runs at 10 MHz and that files include this by bare name.
*/
`ifndef APC_DEFS_VH
`define APC_DEFS_VH

// ----------------------------------------------------------------------
// Command codes
// ----------------------------------------------------------------------
`define APC_CMD_CLEAR_FAULTS      8'h03
`define APC_CMD_INT_CONFIG        8'hDD
`define APC_CMD_FORCE_POLARITY    8'hDE

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define APC_INT_CONFIG_RST        16'h0000
`define APC_FORCE_POLARITY_RST    8'h00

// ----------------------------------------------------------------------
// Interrupt configuration word fields
// ----------------------------------------------------------------------
`define APC_B_BYPASS_OV           14
`define APC_B_BYPASS_UV           13
`define APC_B_BYPASS_OC           12
`define APC_A_BYPASS_OV           11
`define APC_A_BYPASS_UV           10
`define APC_A_BYPASS_OC           9
`define APC_OC_TIME_HI            8
`define APC_OC_TIME_LO            7
`define APC_UV_TIME_HI            6
`define APC_UV_TIME_LO            5
`define APC_OV_TIME_HI            4
`define APC_OV_TIME_LO            3
`define APC_OC_ON_BIT             2
`define APC_OV_ON_BIT             1
`define APC_UV_ON_BIT             0
`define APC_INT_CONFIG_MASK       16'h7FFF

// ----------------------------------------------------------------------
// Force and polarity byte fields
// ----------------------------------------------------------------------
`define APC_B_LEVEL_BIT           3
`define APC_A_LEVEL_BIT           2
`define APC_B_FORCE_BIT           1
`define APC_A_FORCE_BIT           0
`define APC_FORCE_POLARITY_MASK   8'h0F

// ----------------------------------------------------------------------
// Glitch filter timing
// ----------------------------------------------------------------------
`define APC_REF_CLK_MHZ           10
`define APC_FILT_T0_US            0
`define APC_FILT_T1_US            2
`define APC_FILT_T2_US            4
`define APC_FILT_T3_US            8
// Cycle counts are the times above at 10 MHz, sized for the filter counter
`define APC_FILT_T0_CYC           7'h00
`define APC_FILT_T1_CYC           7'h14
`define APC_FILT_T2_CYC           7'h28
`define APC_FILT_T3_CYC           7'h50
`define APC_FILT_CNT_W            7

`endif

// File: testbench/alert_pin_conditioning_tb.sv
/* Testbench for apc_alert_top: register access, filters, bypass,
   force and polarity. Assumes the decoded strobe port of the top. */
`timescale 1ns/100ps
`include "apc_defs.vh"
bind apc_alert_top apc_alert_properties u_chk (.ref_clk(ref_clk), .rst_n(rst_n),
  .reg_cmd(reg_cmd), .reg_wr(reg_wr), .reg_send(reg_send), .reg_rd(reg_rd),
  .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
  .ov_cmp_in(ov_cmp_in), .ot_cmp_in(ot_cmp_in), .uv_cmp_in(uv_cmp_in),
  .oc_cmp_in(oc_cmp_in), .overcurrent_comp_on(overcurrent_comp_on),
  .overvoltage_comp_on(overvoltage_comp_on), .undervoltage_comp_on(undervoltage_comp_on),
  .ov_flag(ov_flag), .uv_flag(uv_flag), .oc_flag(oc_flag), .overtemp_flag(overtemp_flag),
  .alert_out_a_o(alert_out_a_o), .alert_out_a_oe(alert_out_a_oe), .alert_out_b(alert_out_b));

module alert_pin_conditioning_tb;
  localparam [2:0] WR = 3'h1;
  localparam [2:0] SD = 3'h2;
  reg         ref_clk, rst_n, reg_wr, reg_send, reg_rd, ot;
  reg  [7:0]  reg_cmd;
  reg  [15:0] reg_wdata;
  reg  [2:0]  cmp;
  wire [15:0] reg_rdata;
  wire [2:0]  en_out, flg;
  wire        reg_rvalid, ot_flag, a_o, a_oe, b_o, pin_a, pin_b;
  integer     failures, checked, i, j, k, n;
  int         nc[4] = '{0, 20, 40, 80};
  int         en[3] = '{1, 0, 2};
  int         lo[3] = '{3, 5, 7};
  int         bb[3] = '{14, 13, 12};
  int         ba[3] = '{11, 10, 9};

  apc_alert_top dut (.ref_clk(ref_clk), .rst_n(rst_n), .reg_cmd(reg_cmd),
    .reg_wr(reg_wr), .reg_send(reg_send), .reg_rd(reg_rd), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .ov_cmp_in(cmp[0]),
    .ot_cmp_in(ot), .uv_cmp_in(cmp[1]), .oc_cmp_in(cmp[2]),
    .overcurrent_comp_on(en_out[2]), .overvoltage_comp_on(en_out[1]),
    .undervoltage_comp_on(en_out[0]), .ov_flag(flg[0]), .uv_flag(flg[1]),
    .oc_flag(flg[2]), .overtemp_flag(ot_flag), .alert_out_a_o(a_o),
    .alert_out_a_oe(a_oe), .alert_out_b(b_o));
  apc_host_irq_model host (.alert_out_a_o(a_o), .alert_out_a_oe(a_oe),
    .alert_out_b(b_o), .pin_a(pin_a), .pin_b(pin_b));

  initial begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
  end

  task chk(input [15:0] seen, input [15:0] exp);
    checked = checked + 1;
    if (seen !== exp) begin
      failures = failures + 1;
      $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task cyc(input integer m);
    repeat (m) @(posedge ref_clk);
    #1;
  endtask
  // One strobe cycle; the host sends no data byte with clear
  task acc(input [2:0] op, input [7:0] c, input [15:0] d);
    @(posedge ref_clk);
    reg_cmd <= c;
    reg_wdata <= d;
    {reg_rd, reg_send, reg_wr} <= op;
    @(posedge ref_clk);
    {reg_rd, reg_send, reg_wr} <= 3'h0;
  endtask
  task rd(input [7:0] c, input [15:0] e);
    acc(3'h4, c, 16'h0000);
    #1;
    chk(reg_rvalid, 16'h0001);
    chk(reg_rdata, e);
  endtask
  // Expected pin levels with both polarities active low
  task pins(input ea, input eb);
    chk(pin_a, !ea);
    chk(pin_b, !eb);
  endtask
  task done(input string s);
    $display("Test %0s finished", s);
  endtask
  task finish_test;
    $display("Comparisons %0d, mismatches %0d", checked, failures);
    if (failures == 0 && checked > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  // Bound kept loose: the full run needs about 1430 cycles
  initial begin
    #1000000;
    failures = failures + 1;
    finish_test;
  end

  initial begin
    rst_n = 1'b0;
    {reg_wr, reg_send, reg_rd, ot} = 4'h0;
    reg_cmd = 8'h00;
    reg_wdata = 16'h0000;
    cmp = 3'h0;
    failures = 0;
    checked = 0;
    repeat (2) @(posedge ref_clk);
    rst_n <= 1'b1;
    cyc(1);
    pins(0, 0);
    rd(`APC_CMD_INT_CONFIG, 16'h0000);
    rd(`APC_CMD_FORCE_POLARITY, 16'h0000);
    done("reset");
    acc(WR, `APC_CMD_INT_CONFIG, 16'hFFFF);
    rd(`APC_CMD_INT_CONFIG, 16'h7FFF);
    chk(en_out, 16'h0007);
    acc(WR, `APC_CMD_FORCE_POLARITY, 16'hFFFF);
    rd(`APC_CMD_FORCE_POLARITY, 16'h000F);
    rd(`APC_CMD_CLEAR_FAULTS, 16'h0000);
    acc(WR, 8'h55, 16'h1234);
    rd(8'h55, 16'h0000);
    rd(`APC_CMD_INT_CONFIG, 16'h7FFF);
    acc(WR, `APC_CMD_FORCE_POLARITY, 16'h0000);
    done("registers");
    for (k = 0; k < 3; k = k + 1) begin
      for (j = 0; j < 4; j = j + 1) begin
        n = nc[j];
        acc(WR, `APC_CMD_INT_CONFIG, (16'h1 << en[k]) | (16'(j) << lo[k]));
        if (n > 0) begin
          @(posedge ref_clk);
          cmp[k] <= 1'b1;
          repeat (n) @(posedge ref_clk);
          cmp[k] <= 1'b0;
          cyc(8);
          chk(flg[k], 16'h0000);
        end
        @(posedge ref_clk);
        cmp[k] <= 1'b1;
        cyc(n + 3);
        chk(flg[k], 16'h0000);
        cyc(1);
        chk(flg, 16'h0001 << k);
        cyc(1);
        pins(1, 1);
        @(posedge ref_clk);
        cmp[k] <= 1'b0;
        cyc(10);
        chk(flg[k], 16'h0001);
        acc(SD, `APC_CMD_CLEAR_FAULTS, 16'h0000);
        cyc(2);
        chk(flg[k], 16'h0000);
        pins(0, 0);
      end
    end
    done("filters");
    acc(WR, `APC_CMD_INT_CONFIG, 16'h0002);
    @(posedge ref_clk);
    ot <= 1'b1;
    repeat (6) @(posedge ref_clk);
    ot <= 1'b0;
    cyc(10);
    chk(ot_flag, 16'h0001);
    pins(1, 1);
    acc(SD, `APC_CMD_CLEAR_FAULTS, 16'h0000);
    cyc(2);
    chk(ot_flag, 16'h0000);
    pins(0, 0);
    done("overtemp");
    for (j = 0; j < 6; j = j + 1) begin
      k = j % 3;
      n = (j < 3) ? bb[k] : ba[k];
      acc(WR, `APC_CMD_INT_CONFIG, (16'h1 << en[k]) | (16'h3 << lo[k]) | (16'h1 << n));
      @(posedge ref_clk);
      cmp[k] <= 1'b1;
      cyc(3);
      pins(j >= 3, j < 3);
      @(posedge ref_clk);
      cmp[k] <= 1'b0;
      cyc(3);
      pins(0, 0);
      chk(flg, 16'h0000);
    end
    done("bypass");
    acc(WR, `APC_CMD_INT_CONFIG, 16'h7FF8);
    @(posedge ref_clk);
    cmp <= 3'h7;
    ot <= 1'b1;
    cyc(30);
    chk({ot_flag, flg}, 16'h0000);
    pins(0, 0);
    @(posedge ref_clk);
    cmp <= 3'h0;
    ot <= 1'b0;
    done("disabled");
    for (i = 0; i < 16; i = i + 1) begin
      acc(WR, `APC_CMD_FORCE_POLARITY, 16'(i));
      cyc(3);
      chk(pin_a, i[0] ? i[2] : !i[2]);
      chk(pin_b, i[1] ? i[3] : !i[3]);
    end
    done("force");
    // Both pins forced active low, then a reset must release them
    acc(WR, `APC_CMD_FORCE_POLARITY, 16'h0003);
    cyc(2);
    pins(1, 1);
    @(posedge ref_clk);
    rst_n <= 1'b0;
    repeat (2) @(posedge ref_clk);
    #1;
    pins(0, 0);
    @(posedge ref_clk);
    rst_n <= 1'b1;
    cyc(1);
    pins(0, 0);
    rd(`APC_CMD_INT_CONFIG, 16'h0000);
    rd(`APC_CMD_FORCE_POLARITY, 16'h0000);
    done("midrun reset");
    finish_test;
  end
endmodule // alert_pin_conditioning_tb

// File: testbench/apc_alert_properties.sv
/* Port checker for apc_alert_top.
   Assumes it is bound to the top and sees only its ports. */
`timescale 1ns/100ps
`include "apc_defs.vh"
module apc_alert_properties (
  input wire        ref_clk,
  input wire        rst_n,
  input wire [7:0]  reg_cmd,
  input wire        reg_wr,
  input wire        reg_send,
  input wire        reg_rd,
  input wire [15:0] reg_wdata,
  input wire [15:0] reg_rdata,
  input wire        reg_rvalid,
  input wire        ov_cmp_in,
  input wire        ot_cmp_in,
  input wire        uv_cmp_in,
  input wire        oc_cmp_in,
  input wire        overcurrent_comp_on,
  input wire        overvoltage_comp_on,
  input wire        undervoltage_comp_on,
  input wire        ov_flag,
  input wire        uv_flag,
  input wire        oc_flag,
  input wire        overtemp_flag,
  input wire        alert_out_a_o,
  input wire        alert_out_a_oe,
  input wire        alert_out_b
);
  // ----
  // Shadow copies of the two registers
  // ----
  reg  [15:0] cfg;
  reg  [7:0]  fp;
  wire        clr = reg_send && reg_cmd == `APC_CMD_CLEAR_FAULTS;
  wire        mapped = reg_cmd == `APC_CMD_INT_CONFIG || reg_cmd == `APC_CMD_FORCE_POLARITY;

  always @(posedge ref_clk) begin
    if (!rst_n) begin
      cfg <= `APC_INT_CONFIG_RST;
      fp <= `APC_FORCE_POLARITY_RST;
    end else if (reg_wr && reg_cmd == `APC_CMD_INT_CONFIG) begin
      cfg <= reg_wdata & `APC_INT_CONFIG_MASK;
    end else if (reg_wr && reg_cmd == `APC_CMD_FORCE_POLARITY) begin
      fp <= reg_wdata[7:0] & `APC_FORCE_POLARITY_MASK;
    end
  end

  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  // Filter zero needs six sampled cycles of slack
  sequence oc_steady;
    (overcurrent_comp_on && cfg[8:7] == 2'h0 && oc_cmp_in) [*6];
  endsequence
  sequence oc_quiet;
    !oc_cmp_in [*5];
  endsequence

  a_read_strobe: assert property (
    1'b1 |=> reg_rvalid == $past(reg_rd)) else $error("read valid misplaced");
  a_config_read: assert property (
    reg_rd && reg_cmd == `APC_CMD_INT_CONFIG |=> reg_rdata == $past(cfg))
    else $error("config readback wrong");
  a_unmapped_zero: assert property (
    reg_rd && !mapped |=> reg_rdata == 16'h0000) else $error("unmapped read nonzero");
  a_enable_outs: assert property (
    {overcurrent_comp_on, overvoltage_comp_on, undervoltage_comp_on} == cfg[2:0])
    else $error("comparator enables wrong");
  a_flag_sticky: assert property (
    oc_flag && !clr |=> oc_flag) else $error("flag dropped without clear");
  a_clear_flag: assert property (
    oc_quiet ##0 clr |=> !oc_flag) else $error("clear left flag set");
  a_off_no_flag: assert property (
    !overcurrent_comp_on [*8] |-> !$rose(oc_flag)) else $error("disabled comparator set flag");
  a_steady_sets: assert property (
    oc_steady |-> oc_flag) else $error("steady event not latched");
  a_force_b: assert property (
    (fp[1] && $stable(fp)) [*3] |-> alert_out_b == fp[3]) else $error("pin B force wrong");
  a_force_a: assert property (
    (fp[0] && $stable(fp)) [*3] |-> alert_out_a_oe == !fp[2]) else $error("pin A force wrong");
  a_drain_low: assert property (
    alert_out_a_oe |-> !alert_out_a_o) else $error("pin A drives high");
endmodule // apc_alert_properties

// File: testbench/apc_host_irq_model.sv
/* Host interrupt input seen from the far side of both alert pins.
   Assumes a pull-up on pin A, as an open-drain line needs. */
`timescale 1ns/100ps
module apc_host_irq_model (
  input wire  alert_out_a_o,
  input wire  alert_out_a_oe,
  input wire  alert_out_b,
  output wire pin_a,
  output wire pin_b
);
  assign pin_a = alert_out_a_oe ? alert_out_a_o : 1'b1;
  assign pin_b = alert_out_b;
endmodule // apc_host_irq_model
